/* File: pkg/tsi_pkg.sv */
package tsi_pkg;

    // Clock and bus timing, figures in their own units
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned FAST_HIGH_NS  = 600;
    // Shortest fast-mode SCL high time in clk_i cycles, rounded up
    localparam int unsigned FAST_HIGH_CYC =
        (FAST_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Control byte: device-type code (arbitrary value) and select bits
    localparam logic [3:0] DEV_TYPE_DFLT   = 4'hA;
    localparam logic [2:0] DEV_SELECT_DFLT = 3'h0;

    // Bits of data per byte, before the acknowledge bit
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Register select pointer values and reset
    localparam logic [7:0] PTR_TEMP   = 8'h00;
    localparam logic [7:0] PTR_CONFIG = 8'h01;
    localparam logic [7:0] PTR_HYST   = 8'h02;
    localparam logic [7:0] PTR_OVT    = 8'h03;
    localparam logic [7:0] PTR_RST    = PTR_TEMP;

    // Write byte index within a write transfer
    localparam logic [1:0] IDX_PTR = 2'h0;
    localparam logic [1:0] IDX_MSB = 2'h1;
    localparam logic [1:0] IDX_LSB = 2'h2;

    // Setpoint values after reset: 80 C and 75 C
    localparam logic [15:0] OVT_RST = 16'h5000;
    localparam logic [15:0] HYS_RST = 16'h4B00;
    localparam logic [15:0] RD_NONE = 16'h0000;

    // Setpoint layout: bits 3..0 always zero
    localparam logic [3:0]  SP_ZERO_NIB = 4'h0;

    // Comparator masks per resolution code (9, 10, 11, 12 bits)
    localparam logic [1:0]  RES_9  = 2'h0;
    localparam logic [1:0]  RES_10 = 2'h1;
    localparam logic [1:0]  RES_11 = 2'h2;
    localparam logic [15:0] MASK_9  = 16'hFF80;
    localparam logic [15:0] MASK_10 = 16'hFFC0;
    localparam logic [15:0] MASK_11 = 16'hFFE0;
    localparam logic [15:0] MASK_12 = 16'hFFF0;

    // Bus protocol engine states
    typedef enum logic [7:0] {
        ST_IDLE     = 8'h01,
        ST_ADDR     = 8'h02,
        ST_ADDR_ACK = 8'h04,
        ST_RXD      = 8'h08,
        ST_RX_ACK   = 8'h10,
        ST_TXD      = 8'h20,
        ST_TX_ACK   = 8'h40,
        ST_IGNORE   = 8'h80
    } tsi_state_t;

endpackage

/* File: pkg/tsi_sp_if.sv */
`timescale 1ns/100ps
// Write port and read-back of one setpoint register
interface tsi_sp_if;
    logic        wr;
    logic [15:0] wdata;
    logic [1:0]  res;
    logic [15:0] value;
    logic [15:0] cmp_value;

    modport owner (input wr, input wdata, input res,
                   output value, output cmp_value);
    modport user  (output wr, output wdata, output res,
                   input value, input cmp_value);
endinterface

/* File: rtl/tsi_sync.sv */
`timescale 1ns/100ps
module tsi_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // Asynchronous level in, synchronised level out
    input  wire logic d_i,
    output logic      q_o
);

    logic meta_q;
    logic sync_q;

    // Two flops; only the second one is visible outside
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule // tsi_sync

/* File: rtl/tsi_setpoint_reg.sv */
`timescale 1ns/100ps
module tsi_setpoint_reg
    import tsi_pkg::*;
#(
    parameter logic [15:0] RST_VAL = 16'h0000
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // Register port
    tsi_sp_if.owner   sp
);

    logic [15:0] value_q;
    logic [15:0] cmp_q;
    logic [15:0] mask;

    // Volatile store; free for scratch data when the thermostat is unused
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            value_q <= RST_VAL;
        end else if (sp.wr) begin
            value_q <= {sp.wdata[15:4], SP_ZERO_NIB};
        end
    end

    // Fraction bits finer than the resolution are hidden from the comparator
    always_comb begin
        case (sp.res)
            RES_9:   mask = MASK_9;
            RES_10:  mask = MASK_10;
            RES_11:  mask = MASK_11;
            default: mask = MASK_12;
        endcase
    end

    // Registered so the comparator sees a clean flop output
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_q <= RST_VAL;
        end else begin
            cmp_q <= value_q & mask;
        end
    end

    assign sp.value     = value_q;
    assign sp.cmp_value = cmp_q;

    store_word_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        sp.wr |=> value_q == {$past(sp.wdata[15:4]), SP_ZERO_NIB})
        else $error("setpoint did not store written word");

    cmp_mask_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $past(sp.res) == RES_9 |-> cmp_q[6:0] == 7'h00)
        else $error("comparator value keeps unused fraction bits");

endmodule // tsi_setpoint_reg

/* File: rtl/tsi_top.sv */
`timescale 1ns/100ps
// Behaviour
// - Setpoints hold 16-bit two's complement Celsius, low four bits zero.
// - Setpoint bits are usable as volatile scratch storage.
// - SDA change while SCL high is a control condition, not data.
// - SDA falling while SCL high is a start.
// - SDA rising while SCL high is a stop, ending the transfer.
// - One SCL pulse per bit; data changes only while SCL low.
// - Eight-bit bytes, each acknowledged; master sets byte count.
// - Works at both 100 kHz and 400 kHz SCL.
// - Acknowledger holds SDA low through the ninth clock high.
// - Master withholds last read acknowledge; device then releases SDA.
// - In writes, device acknowledges address and every data byte.
// - In reads, device acknowledges address, then sends data bytes.
// - Repeated start ends one transfer and begins the next.
// - Address matched in hardware after seven bits and direction.
// - Control byte: type code, three select bits, direction bit.
// - Select bits match a per-variant value, zero by default.
// - Direction bit one reads, zero writes.
// - Acknowledge the control byte only on a full match.
// - Slave only: never drives SCL, open-drain pull-low on SDA.
// - In transmit, shift data out on master's clock after control byte.
// - Write sends pointer byte first, before any data.
// - Pointer three selects over-temperature, two selects hysteresis.
// - Comparator ignores fraction bits below chosen resolution.
module tsi_top
    import tsi_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE   = DEV_TYPE_DFLT,
    parameter logic [2:0] DEV_SELECT = DEV_SELECT_DFLT
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Serial clock pin, open drain
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_o,
    // Serial data pin, open drain
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    // Thermostat side
    input  wire logic [1:0]  res_i,
    output logic [15:0]      ovt_setpoint_o,
    output logic [15:0]      hys_setpoint_o,
    output logic             busy_o
);

    tsi_state_t  state_q;
    tsi_state_t  state_d;
    logic        scl_s;
    logic        sda_s;
    logic        scl_q;
    logic        sda_q;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic        line_event;
    logic        line_event_ctl;
    logic        addr_match;
    logic        byte_done;
    logic [3:0]  bitcnt_q;
    logic [7:0]  shift_q;
    logic [7:0]  tx_q;
    logic        rw_q;
    logic        nack_q;
    logic        tx_lsb_q;
    logic [1:0]  byte_idx_q;
    logic [7:0]  ptr_q;
    logic [7:0]  msb_q;
    logic [15:0] wdata_q;
    logic        ovt_wr_q;
    logic        hys_wr_q;
    logic        sda_oe_q;
    logic        low_q;
    logic        busy_q;
    logic [15:0] rd_word;
    logic [7:0]  rd_byte;

    tsi_sp_if ovt_if ();
    tsi_sp_if hys_if ();

    // Pins cross into clk_i; at 400 kHz SCL high lasts FAST_HIGH_CYC
    // cycles, well above the three-cycle sampling delay
    tsi_sync #(.RST_VAL(1'b1)) u_scl_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      (scl_i),
        .q_o      (scl_s)
    );

    tsi_sync #(.RST_VAL(1'b1)) u_sda_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      (sda_i),
        .q_o      (sda_s)
    );

    // Previous synchronised levels for edge detection
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // Bus conditions; a start needs both lines high just before
    assign scl_rise  = scl_s & ~scl_q;
    assign scl_fall  = ~scl_s & scl_q;
    assign start_det = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;
    assign line_event = scl_fall | start_det | stop_det;
    assign line_event_ctl = start_det | stop_det;
    assign byte_done  = (bitcnt_q == BITS_PER_BYTE);

    // Type code and select bits in the top seven, direction bit last
    assign addr_match = (shift_q[7:1] == {DEV_TYPE, DEV_SELECT});

    // Read data source chosen by the pointer
    always_comb begin
        case (ptr_q)
            PTR_OVT:  rd_word = ovt_if.value;
            PTR_HYST: rd_word = hys_if.value;
            default:  rd_word = RD_NONE;
        endcase
    end
    assign rd_byte = tx_lsb_q ? rd_word[7:0] : rd_word[15:8];

    // Next state; stop and start win over any bit in progress
    always_comb begin
        state_d = state_q;
        if (stop_det) begin
            state_d = ST_IDLE;
        end else if (start_det) begin
            state_d = ST_ADDR;
        end else if (scl_fall) begin
            case (state_q)
                ST_ADDR: begin
                    if (byte_done) begin
                        state_d = addr_match ? ST_ADDR_ACK : ST_IGNORE;
                    end
                end
                ST_ADDR_ACK: begin
                    state_d = rw_q ? ST_TXD : ST_RXD;
                end
                ST_RXD: begin
                    if (byte_done) begin
                        state_d = ST_RX_ACK;
                    end
                end
                ST_RX_ACK: begin
                    state_d = ST_RXD;
                end
                ST_TXD: begin
                    if (byte_done) begin
                        state_d = ST_TX_ACK;
                    end
                end
                ST_TX_ACK: begin
                    state_d = nack_q ? ST_IGNORE : ST_TXD;
                end
                default: begin
                    state_d = state_q;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Bit counter: one count per SCL rise in a data phase
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bitcnt_q <= 4'h0;
        end else if (start_det || (state_d != state_q)) begin
            bitcnt_q <= 4'h0;
        end else if (scl_rise && (state_q == ST_ADDR ||
                     state_q == ST_RXD || state_q == ST_TXD)) begin
            bitcnt_q <= bitcnt_q + 4'h1;
        end
    end

    // Receive shifter samples SDA at SCL rise, MSB first
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shift_q <= 8'h00;
        end else if (scl_rise &&
                     (state_q == ST_ADDR || state_q == ST_RXD)) begin
            shift_q <= {shift_q[6:0], sda_s};
        end
    end

    // Direction bit and master acknowledge
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rw_q   <= 1'b0;
            nack_q <= 1'b0;
        end else begin
            if (scl_fall && state_q == ST_ADDR && byte_done) begin
                rw_q <= shift_q[0];
            end
            if (scl_rise && state_q == ST_TX_ACK) begin
                nack_q <= sda_s;
            end
        end
    end

    // Pointer and setpoint writes; a word lands after its low byte
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ptr_q      <= PTR_RST;
            msb_q      <= 8'h00;
            byte_idx_q <= IDX_PTR;
            wdata_q    <= 16'h0000;
            ovt_wr_q   <= 1'b0;
            hys_wr_q   <= 1'b0;
        end else begin
            ovt_wr_q <= 1'b0;
            hys_wr_q <= 1'b0;
            if (start_det) begin
                byte_idx_q <= IDX_PTR;
            end else if (scl_fall && state_q == ST_RXD && byte_done) begin
                case (byte_idx_q)
                    IDX_PTR: begin
                        ptr_q      <= shift_q;
                        byte_idx_q <= IDX_MSB;
                    end
                    IDX_MSB: begin
                        msb_q      <= shift_q;
                        byte_idx_q <= IDX_LSB;
                    end
                    default: begin
                        wdata_q    <= {msb_q, shift_q};
                        ovt_wr_q   <= (ptr_q == PTR_OVT);
                        hys_wr_q   <= (ptr_q == PTR_HYST);
                        byte_idx_q <= IDX_MSB;
                    end
                endcase
            end
        end
    end

    // Transmit byte: load on entry to a data phase, shift at each fall in the byte but the eighth
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_q     <= 8'h00;
            tx_lsb_q <= 1'b0;
        end else if (scl_fall && !start_det && !stop_det) begin
            if (state_q == ST_ADDR_ACK) begin
                tx_lsb_q <= 1'b0;
                tx_q     <= rd_word[15:8];
            end else if (state_q == ST_TX_ACK) begin
                tx_q <= rd_byte;
            end else if (state_q == ST_TXD && byte_done) begin
                tx_lsb_q <= ~tx_lsb_q;
            end else if (state_q == ST_TXD) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // SDA pull-low; changes just after SCL falls, and is released at a start or stop;
    // data and acknowledge are steady through every SCL high
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sda_oe_q <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe_q <= 1'b0;
        end else if (scl_fall) begin
            case (state_d)
                ST_ADDR_ACK: sda_oe_q <= 1'b1;
                ST_RX_ACK:   sda_oe_q <= 1'b1;
                ST_TXD: begin
                    if (state_q == ST_ADDR_ACK) begin
                        sda_oe_q <= ~rd_word[15];
                    end else if (state_q == ST_TX_ACK) begin
                        sda_oe_q <= ~rd_byte[7];
                    end else begin
                        sda_oe_q <= ~tx_q[6];
                    end
                end
                default:     sda_oe_q <= 1'b0;
            endcase
        end
    end

    // Pins only ever pull low; SCL is never driven
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_q  <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            low_q  <= 1'b0;
            busy_q <= (state_d != ST_IDLE) && (state_d != ST_IGNORE);
        end
    end

    // Setpoint storage
    assign ovt_if.wr    = ovt_wr_q;
    assign ovt_if.wdata = wdata_q;
    assign ovt_if.res   = res_i;
    assign hys_if.wr    = hys_wr_q;
    assign hys_if.wdata = wdata_q;
    assign hys_if.res   = res_i;

    tsi_setpoint_reg #(.RST_VAL(OVT_RST)) u_ovt (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .sp       (ovt_if.owner)
    );

    tsi_setpoint_reg #(.RST_VAL(HYS_RST)) u_hys (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .sp       (hys_if.owner)
    );

    // Outputs
    assign sda_o          = low_q;
    assign sda_oe_o       = sda_oe_q;
    assign scl_o          = low_q;
    assign scl_oe_o       = low_q;
    assign ovt_setpoint_o = ovt_if.cmp_value;
    assign hys_setpoint_o = hys_if.cmp_value;
    assign busy_o         = busy_q;

    // Checks on the protocol engine
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_addr_done;
        scl_fall && state_q == ST_ADDR && byte_done;
    endsequence

    sequence s_rx_done;
        scl_fall && state_q == ST_RXD && byte_done && !line_event_ctl;
    endsequence

    sequence s_nack_seen;
        scl_fall && state_q == ST_TX_ACK && nack_q;
    endsequence

    start_enter_a: assert property (start_det && !stop_det |=>
        state_q == ST_ADDR && !sda_oe_q && bitcnt_q == 4'h0)
        else $error("start did not open an address phase");

    stop_idle_a: assert property (stop_det |=>
        state_q == ST_IDLE && !sda_oe_q)
        else $error("stop did not release the bus");

    addr_ack_a: assert property (s_addr_done ##0 addr_match |=>
        state_q == ST_ADDR_ACK && sda_oe_q)
        else $error("matching control byte not acknowledged");

    no_match_a: assert property (s_addr_done ##0 !addr_match |=>
        state_q == ST_IGNORE && !sda_oe_q)
        else $error("mismatched control byte was acknowledged");

    ignore_quiet_a: assert property (state_q == ST_IGNORE |->
        !sda_oe_q && !busy_q)
        else $error("data line driven while not addressed");

    oe_edge_a: assert property ($changed(sda_oe_q) |->
        $past(line_event))
        else $error("data line changed away from a clock fall");

    rx_ack_a: assert property (s_rx_done |=>
        state_q == ST_RX_ACK && sda_oe_q)
        else $error("received byte not acknowledged");

    nack_free_a: assert property (s_nack_seen |=>
        !sda_oe_q && state_q == ST_IGNORE)
        else $error("data line not released after master nack");

    first_bit_a: assert property (scl_fall && state_q == ST_ADDR_ACK &&
        rw_q && !line_event_ctl |=> sda_oe_q == !$past(rd_word[15]))
        else $error("first read bit wrong");

    scl_free_a: assert property (!scl_oe_o && !sda_o)
        else $error("clock line driven or data driven high");

    sel_write_a: assert property (ovt_wr_q |-> ptr_q == PTR_OVT &&
        !hys_wr_q)
        else $error("over-temperature write with wrong pointer");

    ptr_first_a: assert property (s_rx_done ##0 byte_idx_q == IDX_PTR
        |=> ptr_q == $past(shift_q) && !ovt_wr_q && !hys_wr_q)
        else $error("first written byte not taken as pointer");

endmodule // tsi_top

/* File: dv/tsi_master_model.sv */
`timescale 1ns/100ps
// Bus master on the serial link: pulls lines low, never drives them high
module tsi_master_model (
    // Clock
    input  wire logic clk_i,
    // Data wire level
    input  wire logic sda_i,
    // Pull-low enables
    output logic      scl_oe_o,
    output logic      sda_oe_o
);
    // Both lines released from time zero, so the bus starts idle
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end

    // Steps land on the falling edge, away from the sampling edge
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Start or repeated start, from idle or from SCL low
    task automatic start();
        sda_oe_o = 1'b0;
        wt(3);
        scl_oe_o = 1'b0;
        wt(4);
        sda_oe_o = 1'b1;
        wt(4);
        scl_oe_o = 1'b1;
        wt(2);
    endtask

    // Stop: data released while the clock is high
    task automatic stop();
        sda_oe_o = 1'b1;
        wt(3);
        scl_oe_o = 1'b0;
        wt(4);
        sda_oe_o = 1'b0;
        wt(4);
    endtask

    // One bit, 800 ns: four cycles low, four high; the slave moves SDA
    // about 2.5 cycles after the fall, so it settles before the rise
    task automatic bitx(input logic b, output logic s);
        sda_oe_o = ~b;
        wt(2);
        scl_oe_o = 1'b0;
        wt(2);
        s = sda_i;
        wt(2);
        scl_oe_o = 1'b1;
        wt(2);
    endtask

    // Eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ackb,
                        output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
        bitx(ackb, a);
    endtask
endmodule // tsi_master_model

/* File: dv/tb_thermo_setpoint_i2c_slave.sv */
`timescale 1ns/100ps
module tb_thermo_setpoint_i2c_slave;
    import tsi_pkg::*;
    logic        clk;
    logic        resetn;
    logic [1:0]  res;
    logic        scl;
    logic        sda;
    logic        m_scl_oe;
    logic        m_sda_oe;
    logic        d_scl_oe;
    logic        d_sda_oe;
    logic        d_scl_lvl;
    logic        d_sda_lvl;
    logic [15:0] ovt;
    logic [15:0] hys;
    logic        busy;
    logic [7:0]  rb;
    logic        ack;
    int          bad_count;
    int          checks;
    logic [15:0] masks [4] = '{MASK_9, MASK_10, MASK_11, MASK_12};
    logic [7:0]  bad [2] = '{{DEV_TYPE_DFLT, 3'h1, 1'b0},
                             {~DEV_TYPE_DFLT, DEV_SELECT_DFLT, 1'b0}};

    // Pull-ups: a line is low only while some party pulls it
    assign scl = ~(m_scl_oe | d_scl_oe);
    assign sda = ~(m_sda_oe | d_sda_oe);

    tsi_top dut (.clk_i(clk), .resetn_i(resetn), .scl_i(scl),
        .scl_o(d_scl_lvl), .scl_oe_o(d_scl_oe), .sda_i(sda),
        .sda_o(d_sda_lvl), .sda_oe_o(d_sda_oe),
        .res_i(res), .ovt_setpoint_o(ovt), .hys_setpoint_o(hys),
        .busy_o(busy));
    tsi_master_model m (.clk_i(clk), .sda_i(sda), .scl_oe_o(m_scl_oe),
        .sda_oe_o(m_sda_oe));

    // 10 MHz system clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] ctl(input logic rd);
        return {DEV_TYPE_DFLT, DEV_SELECT_DFLT, rd};
    endfunction

    // Address for writing and set the pointer
    task automatic point(input logic [7:0] ptr);
        m.start();
        m.xfer(ctl(1'b0), 1'b1, rb, ack);
        check("ctrl ack", {15'h0, ack}, 16'h0);
        check("busy", {15'h0, busy}, 16'h1);
        m.xfer(ptr, 1'b1, rb, ack);
        check("ptr ack", {15'h0, ack}, 16'h0);
    endtask

    task automatic wr_reg(input logic [7:0] ptr, input logic [15:0] w);
        point(ptr);
        m.xfer(w[15:8], 1'b1, rb, ack);
        check("msb ack", {15'h0, ack}, 16'h0);
        m.xfer(w[7:0], 1'b1, rb, ack);
        check("lsb ack", {15'h0, ack}, 16'h0);
        m.stop();
        m.wt(4);
    endtask

    // Three bytes read after a repeated start; the last is refused
    task automatic rd_reg(input logic [7:0] ptr, input logic [15:0] e);
        point(ptr);
        m.start();
        m.xfer(ctl(1'b1), 1'b1, rb, ack);
        check("rd ack", {15'h0, ack}, 16'h0);
        m.xfer(8'hFF, 1'b0, rb, ack);
        check("rd msb", {8'h0, rb}, {8'h0, e[15:8]});
        m.xfer(8'hFF, 1'b0, rb, ack);
        check("rd lsb", {8'h0, rb}, {8'h0, e[7:0]});
        m.xfer(8'hFF, 1'b1, rb, ack);
        check("rd again", {8'h0, rb}, {8'h0, e[15:8]});
        m.wt(2);
        check("released", {15'h0, d_sda_oe}, 16'h0);
        m.stop();
        check("idle", {15'h0, busy}, 16'h0);
    endtask

    // Main sequence; inputs move on the falling edge
    initial begin
        resetn = 1'b0;
        res = 2'h0;
        bad_count = 0;
        checks = 0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        m.wt(4);
        check("ovt reset", ovt, 16'h5000);
        check("hys reset", hys, 16'h4B00);
        wr_reg(8'h03, 16'h123F);
        res = 2'h3;
        m.wt(4);
        check("scl oe", {15'h0, d_scl_oe}, 16'h0);
        check("scl out", {15'h0, d_scl_lvl}, 16'h0);
        check("sda out", {15'h0, d_sda_lvl}, 16'h0);
        check("ovt", ovt, 16'h1230);
        wr_reg(8'h02, 16'hF5E7);
        check("hys", hys, 16'hF5E0);
        rd_reg(8'h02, 16'hF5E0);
        wr_reg(8'h03, 16'hFFFF);
        for (int i = 0; i < 4; i++) begin
            res = i[1:0];
            m.wt(4);
            check("ovt mask", ovt, masks[i]);
        end
        // Foreign control bytes: no acknowledge, later bytes ignored
        for (int i = 0; i < 2; i++) begin
            m.start();
            m.xfer(bad[i], 1'b1, rb, ack);
            check("foreign", {15'h0, ack}, 16'h1);
            m.xfer(8'h02, 1'b1, rb, ack);
            m.xfer(8'h00, 1'b1, rb, ack);
            check("ignored", {15'h0, ack}, 16'h1);
            m.stop();
        end
        m.wt(4);
        check("hys kept", hys, 16'hF5E0);
        finish_test();
    end

    // Watchdog, about fifteen times the expected run length
    initial begin
        #3000000;
        bad_count++;
        finish_test();
    end
endmodule // tb_thermo_setpoint_i2c_slave
